// [include/fsp_pkg.sv]
// Purpose: Constants and types for the fast-settling sinc3 postfilter.
// Assumes: One 100 MHz clock; modulator samples arrive as strobes.
// Notes: Register word offsets are byte addresses on the AHB-Lite bus.
package fsp_pkg;
    localparam int unsigned RATE_W = 10;
    localparam int unsigned DEC_UNIT = 1024;
    localparam int unsigned SIXTY_HZ_NOTCH_ENABLE_NUM = 5;
    localparam int unsigned SIXTY_HZ_NOTCH_ENABLE_DEN = 6;
    localparam int unsigned SINC_ORDER = 3;
    localparam int unsigned WORD_W = 64;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned LEVEL_W = 4;
    localparam int unsigned PER_CNT_W = 5;
    localparam int unsigned SIXTY_HZ_NOTCH_ENABLE_MIN_RATE = 2;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_COUNT = 32'h0000_0008;

    localparam int unsigned EN_BIT = 0;
    localparam int unsigned AVG_LOW_BIT = 1;
    localparam int unsigned AVG_HIGH_BIT = 2;
    localparam int unsigned CHOP_BIT = 3;
    localparam int unsigned SIXTY_HZ_NOTCH_ENABLE_BIT = 4;
    localparam int unsigned RATE_LSB = 8;
    localparam int unsigned ST_RUN_BIT = 0;
    localparam int unsigned ST_POL_BIT = 1;
    localparam int unsigned ST_PREV_BIT = 2;
    localparam int unsigned ST_PUSH_BIT = 3;
    localparam int unsigned ST_PER_LSB = 8;
    localparam int unsigned ST_LEVEL_LSB = 16;
    localparam logic [RATE_W-1:0] RATE_RESET = 10'h060;

    typedef logic [19:0] fsp_per_t;
    typedef logic signed [63:0] fsp_word_t;
    typedef logic signed [67:0] fsp_sum_t;

    typedef struct packed {
        logic [RATE_W-1:0] rate_word;
        logic sixty_hz_notch_enable;
        logic chop_enable;
        logic average_select_high;
        logic average_select_low;
        logic enable;
    } fsp_ctrl_t;

    localparam fsp_ctrl_t CTRL_RESET = '{rate_word: RATE_RESET, default: 1'b0};

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } fsp_state_t;
endpackage : fsp_pkg

// [rtl/fsp_filter.sv]
// Purpose: Sinc3 decimator with fast-settling averaging postfilter.
// Assumes: Modulator bits come with a strobe per master clock sample.
// Notes: Results leave through an 8-word FIFO with valid/ready.
`timescale 1ns/100ps

module fsp_fifo #(
    parameter int unsigned WIDTH = fsp_pkg::WORD_W,
    parameter int unsigned DEPTH = fsp_pkg::FIFO_DEPTH
) (
    input logic hclk,
    input logic hresetn,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [$clog2(DEPTH)-1:0] wp;
        logic [$clog2(DEPTH)-1:0] rp;
        logic [$clog2(DEPTH):0] cnt;
        logic not_full;
        logic not_empty;
    } fsp_fifo_state_t;

    fsp_fifo_state_t r;
    fsp_fifo_state_t n;
    logic do_push;
    logic do_pop;

    always_comb begin
        n = r;
        do_push = in_valid && r.not_full;
        do_pop = out_ready && r.not_empty;
        if (do_push) begin
            n.mem[r.wp] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (do_pop) begin
            n.rp = r.rp + 1'b1;
        end
        if (do_push && !do_pop) begin
            n.cnt = r.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            n.cnt = r.cnt - 1'b1;
        end
        n.not_full = n.cnt != ($clog2(DEPTH) + 1)'(DEPTH);
        n.not_empty = n.cnt != '0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{not_full: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    assign in_ready = r.not_full;
    assign out_valid = r.not_empty;
    assign out_data = r.mem[r.rp];
    assign level = r.cnt;
endmodule : fsp_fifo

module fsp_filter (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input logic mod_bit,
    input logic mod_strobe,
    input logic channel_change,
    output logic mod_ready,
    output logic chop_polarity,
    output logic res_valid,
    input logic res_ready,
    output logic [63:0] res_data
);
    typedef struct packed {
        fsp_pkg::fsp_ctrl_t ctrl;
        logic ahb_wr;
        logic [31:0] ahb_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        fsp_pkg::fsp_state_t st;
        fsp_pkg::fsp_per_t ph;
        logic [fsp_pkg::PER_CNT_W-1:0] per;
        fsp_pkg::fsp_word_t i1;
        fsp_pkg::fsp_word_t i2;
        fsp_pkg::fsp_word_t i3;
        logic [fsp_pkg::SINC_ORDER-1:0][63:0] a_hist;
        logic [fsp_pkg::SINC_ORDER-1:0][63:0] b_hist;
        fsp_pkg::fsp_sum_t acc;
        fsp_pkg::fsp_word_t prev;
        logic have_prev;
        logic pol;
        logic push;
        logic [63:0] res;
        logic mod_ready;
        logic [31:0] conv_count;
    } fsp_regs_t;

    fsp_regs_t r;
    fsp_regs_t n;
    fsp_pkg::fsp_ctrl_t ctrl_now;
    logic [fsp_pkg::RATE_W-1:0] rate;
    fsp_pkg::fsp_per_t per_len;
    fsp_pkg::fsp_per_t m_len;
    logic fast;
    logic rej_on;
    logic [2:0] avg_log;
    logic [fsp_pkg::PER_CNT_W-1:0] last_per;
    logic [fsp_pkg::PER_CNT_W-1:0] per_nx;
    fsp_pkg::fsp_per_t ph_nx;
    fsp_pkg::fsp_word_t sv;
    fsp_pkg::fsp_word_t y;
    fsp_pkg::fsp_word_t avg_w;
    fsp_pkg::fsp_word_t ys;
    fsp_pkg::fsp_sum_t acc_nx;
    logic signed [64:0] csum;
    logic cfg_write;
    logic do_clear;
    logic fifo_ready;
    logic [fsp_pkg::LEVEL_W-1:0] fifo_level;

    // Rate word taken as unsigned binary; zero treated as one
    assign rate = (r.ctrl.rate_word == '0) ? 10'h001 : r.ctrl.rate_word;
    assign per_len = fsp_pkg::fsp_per_t'(32'(rate) * fsp_pkg::DEC_UNIT);
    // Third comb of the 60 Hz variant spans rate*5/6 (integer-divided) times 1024 samples
    assign m_len = fsp_pkg::fsp_per_t'(32'(rate) * fsp_pkg::SIXTY_HZ_NOTCH_ENABLE_NUM / fsp_pkg::SIXTY_HZ_NOTCH_ENABLE_DEN
        * fsp_pkg::DEC_UNIT);
    assign rej_on = r.ctrl.sixty_hz_notch_enable
        && (32'(rate) >= fsp_pkg::SIXTY_HZ_NOTCH_ENABLE_MIN_RATE);
    assign fast = r.ctrl.average_select_high || r.ctrl.average_select_low;

    always_comb begin
        unique case ({r.ctrl.average_select_high, r.ctrl.average_select_low})
            2'b01: avg_log = 3'h1;
            2'b10: avg_log = 3'h3;
            2'b11: avg_log = 3'h4;
            2'b00: avg_log = 3'h0;
        endcase
    end

    // Sinc3 settles after three periods, then Avg-1 more are averaged
    assign last_per = fsp_pkg::PER_CNT_W'(fsp_pkg::SINC_ORDER - 1)
        + (fsp_pkg::PER_CNT_W'(1) << avg_log);

    always_comb begin
        n = r;
        ctrl_now = r.ctrl;
        cfg_write = 1'b0;
        do_clear = 1'b0;
        per_nx = r.per;
        ph_nx = r.ph;
        sv = mod_bit ? 64'sh1 : -64'sh1;
        y = '0;
        avg_w = '0;
        ys = '0;
        acc_nx = r.acc;
        csum = '0;

        // AHB-Lite slave, zero wait states
        n.hreadyout = 1'b1;
        n.ahb_wr = 1'b0;
        if (r.ahb_wr && r.ahb_addr == fsp_pkg::ADDR_CTRL) begin
            cfg_write = 1'b1;
            ctrl_now.enable = hwdata[fsp_pkg::EN_BIT];
            ctrl_now.average_select_low = hwdata[fsp_pkg::AVG_LOW_BIT];
            ctrl_now.average_select_high = hwdata[fsp_pkg::AVG_HIGH_BIT];
            ctrl_now.chop_enable = hwdata[fsp_pkg::CHOP_BIT];
            ctrl_now.sixty_hz_notch_enable = hwdata[fsp_pkg::SIXTY_HZ_NOTCH_ENABLE_BIT];
            ctrl_now.rate_word = hwdata[fsp_pkg::RATE_LSB +: fsp_pkg::RATE_W];
        end
        n.ctrl = ctrl_now;
        if (hsel && htrans[1] && hready) begin
            n.ahb_wr = hwrite;
            n.ahb_addr = haddr;
            n.hrdata = '0;
            if (!hwrite) begin
                if (haddr == fsp_pkg::ADDR_CTRL) begin
                    n.hrdata[fsp_pkg::EN_BIT] = ctrl_now.enable;
                    n.hrdata[fsp_pkg::AVG_LOW_BIT] = ctrl_now.average_select_low;
                    n.hrdata[fsp_pkg::AVG_HIGH_BIT] = ctrl_now.average_select_high;
                    n.hrdata[fsp_pkg::CHOP_BIT] = ctrl_now.chop_enable;
                    n.hrdata[fsp_pkg::SIXTY_HZ_NOTCH_ENABLE_BIT] = ctrl_now.sixty_hz_notch_enable;
                    n.hrdata[fsp_pkg::RATE_LSB +: fsp_pkg::RATE_W] = ctrl_now.rate_word;
                end else if (haddr == fsp_pkg::ADDR_STATUS) begin
                    n.hrdata[fsp_pkg::ST_RUN_BIT] = r.st == fsp_pkg::ST_RUN;
                    n.hrdata[fsp_pkg::ST_POL_BIT] = r.pol;
                    n.hrdata[fsp_pkg::ST_PREV_BIT] = r.have_prev;
                    n.hrdata[fsp_pkg::ST_PUSH_BIT] = r.push;
                    n.hrdata[fsp_pkg::ST_PER_LSB +: fsp_pkg::PER_CNT_W] = r.per;
                    n.hrdata[fsp_pkg::ST_LEVEL_LSB +: fsp_pkg::LEVEL_W] = fifo_level;
                end else if (haddr == fsp_pkg::ADDR_COUNT) begin
                    n.hrdata = r.conv_count;
                end
            end
        end

        // Pending result drains into the FIFO
        if (r.push && fifo_ready) begin
            n.push = 1'b0;
            n.conv_count = r.conv_count + 32'h1;
        end

        unique case (r.st)
            fsp_pkg::ST_IDLE: begin
                if (ctrl_now.enable) begin
                    n.st = fsp_pkg::ST_RUN;
                end
            end
            fsp_pkg::ST_RUN: begin
                if (mod_strobe && r.mod_ready) begin
                    n.i1 = r.i1 + sv;
                    n.i2 = r.i2 + n.i1;
                    n.i3 = r.i3 + n.i2;
                    ph_nx = r.ph + 1'b1;
                    n.ph = ph_nx;
                    if (rej_on && ph_nx == per_len - m_len) begin
                        n.b_hist = {r.b_hist[1:0], n.i3};
                    end
                    if (ph_nx == per_len) begin
                        n.ph = '0;
                        n.a_hist = {r.a_hist[1:0], n.i3};
                        per_nx = (fast || r.per < fsp_pkg::PER_CNT_W'(fsp_pkg::SINC_ORDER))
                            ? r.per + 1'b1 : r.per;
                        n.per = per_nx;
                        if (rej_on) begin
                            // Two 1024*rate combs and one m_len comb
                            y = n.i3 - (r.a_hist[0] <<< 1) + r.a_hist[1]
                                - (r.b_hist[0] - (r.b_hist[1] <<< 1) + r.b_hist[2]);
                        end else begin
                            y = n.i3 - r.a_hist[0] - (r.a_hist[0] <<< 1)
                                + r.a_hist[1] + (r.a_hist[1] <<< 1) - r.a_hist[2];
                        end
                        if (per_nx >= fsp_pkg::PER_CNT_W'(fsp_pkg::SINC_ORDER)) begin
                            if (!fast) begin
                                n.res = y;
                                n.push = 1'b1;
                            end else begin
                                acc_nx = r.acc + fsp_pkg::fsp_sum_t'(y);
                                n.acc = acc_nx;
                                if (per_nx == last_per) begin
                                    avg_w = fsp_pkg::fsp_word_t'(acc_nx >>> avg_log);
                                    do_clear = 1'b1;
                                    if (r.ctrl.chop_enable) begin
                                        ys = r.pol ? -avg_w : avg_w;
                                        csum = {ys[63], ys} + {r.prev[63], r.prev};
                                        n.prev = ys;
                                        n.have_prev = 1'b1;
                                        n.pol = !r.pol;
                                        if (r.have_prev) begin
                                            n.res = csum[64:1];
                                            n.push = 1'b1;
                                        end
                                    end else begin
                                        n.res = avg_w;
                                        n.push = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
                if (!ctrl_now.enable) begin
                    n.st = fsp_pkg::ST_IDLE;
                end
            end
        endcase

        // Channel change or new setup restarts the conversion at once
        if (do_clear || cfg_write || channel_change || n.st == fsp_pkg::ST_IDLE) begin
            n.ph = '0;
            n.per = '0;
            n.i1 = '0;
            n.i2 = '0;
            n.i3 = '0;
            n.a_hist = '0;
            n.b_hist = '0;
            n.acc = '0;
        end
        if (cfg_write || channel_change || n.st == fsp_pkg::ST_IDLE
            || !ctrl_now.chop_enable) begin
            n.have_prev = 1'b0;
            n.pol = 1'b0;
            n.prev = '0;
        end
        // Source stalls while a result is pending, until the FIFO takes it
        n.mod_ready = (n.st == fsp_pkg::ST_RUN) && !n.push;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{ctrl: fsp_pkg::CTRL_RESET, st: fsp_pkg::ST_IDLE, hreadyout: 1'b1,
                default: '0};
        end else begin
            r <= n;
        end
    end

    fsp_fifo #(
        .WIDTH(fsp_pkg::WORD_W),
        .DEPTH(fsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(r.push),
        .in_ready(fifo_ready),
        .in_data(r.res),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data),
        .level(fifo_level)
    );

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign mod_ready = r.mod_ready;
    assign chop_polarity = r.pol;
endmodule : fsp_filter

// [tb/fsp_checker.sv]
// Purpose: Port assertions for the sinc3 postfilter.
// Assumes: One clock, async active-low reset.
// Notes: CTRL shadow kept from bus writes.
`timescale 1ns/100ps
module fsp_checker (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [31:0] hwdata,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic mod_ready,
    input logic res_valid,
    input logic res_ready,
    input logic [63:0] res_data
);
    logic [31:0] shadow;
    logic wr_dp;
    logic take;
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shadow <= 32'h0000_6000;
            wr_dp <= 1'b0;
        end else begin
            wr_dp <= take && hwrite && haddr == fsp_pkg::ADDR_CTRL;
            if (wr_dp)
                shadow <= hwdata & 32'h0003_ff1f;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [31:0] a);
        take && !hwrite && haddr == a;
    endsequence
    sequence s_idle2;
        !shadow[fsp_pkg::EN_BIT] ##1 !shadow[fsp_pkg::EN_BIT];
    endsequence
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    AST_NO_WAIT: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    AST_RD_HOLD: assert property (!$past(take) |-> $stable(hrdata))
        else $error("hrdata moved without request");
    AST_READBACK: assert property (s_rd(fsp_pkg::ADDR_CTRL) |=> hrdata == shadow)
        else $error("CTRL readback differs");
    AST_UNMAPPED: assert property (take && !hwrite && haddr > fsp_pkg::ADDR_COUNT
        |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RES_HOLD: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
        else $error("result changed before pop");
    AST_PUSH_STALL: assert property ($rose(res_valid) |->
        !$past(mod_ready) || !$past(mod_ready, 2) || !$past(mod_ready, 3))
        else $error("result without end of conversion");
    AST_IDLE: assert property (s_idle2 |-> !mod_ready)
        else $error("samples taken while disabled");
endmodule : fsp_checker

// [tb/fsp_mod_model.sv]
// Purpose: Modulator model with chopped front end.
// Assumes: Constant input level, one sample per cycle.
// Notes: at_stop holds the sample count at each result.
`timescale 1ns/100ps
module fsp_mod_model (
    input logic hclk,
    input logic hresetn,
    input logic run,
    input logic level,
    input logic clr,
    input logic mod_ready,
    input logic chop_polarity,
    output logic mod_bit,
    output logic mod_strobe,
    output logic [31:0] at_stop
);
    logic [31:0] count;
    logic ready_q;
    logic idle_bit;
    // Swapped inputs invert the bit in the very cycle the polarity changes
    assign mod_bit = mod_strobe ? level ^ chop_polarity : idle_bit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_bit <= 1'b0;
            mod_strobe <= 1'b0;
            count <= 32'h0;
            at_stop <= 32'h0;
            ready_q <= 1'b0;
        end else begin
            ready_q <= mod_ready;
            mod_strobe <= run;
            // Idle line toggles
            idle_bit <= ~idle_bit;
            if (clr)
                count <= 32'h0;
            else if (mod_strobe && mod_ready)
                count <= count + 32'h1;
            if (ready_q && !mod_ready)
                at_stop <= count;
        end
    end
endmodule : fsp_mod_model

// [tb/fsp_filter_tb.sv]
// Purpose: Self-checking bench for the sinc3 postfilter.
// Assumes: Rate word 1 or 2 keeps conversions short.
// Notes: Full scale is N cubed for a constant input, N*N*m_len with the 60 Hz notch.
`timescale 1ns/100ps
module fsp_filter_tb;
    localparam logic [63:0] FS = 64'h0000_0000_4000_0000;
    localparam logic [63:0] NEG = 64'hffff_ffff_c000_0000;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic res_ready = 1'b0;
    logic channel_change = 1'b0;
    logic run = 1'b0;
    logic level = 1'b0;
    logic clr = 1'b0;
    logic [31:0] hrdata, at_stop, q;
    logic hreadyout, hresp, mod_bit, mod_strobe, mod_ready, chop_polarity, res_valid;
    logic [63:0] res_data;
    int avg [1:3] = '{2, 8, 16};
    int n_fail = 0;
    int n_checks = 0;
    int k;
    always #5 hclk = ~hclk;
    fsp_filter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mod_bit(mod_bit),
        .mod_strobe(mod_strobe), .channel_change(channel_change), .mod_ready(mod_ready),
        .chop_polarity(chop_polarity), .res_valid(res_valid), .res_ready(res_ready),
        .res_data(res_data));
    fsp_mod_model u_mod (.hclk(hclk), .hresetn(hresetn), .run(run), .level(level), .clr(clr),
        .mod_ready(mod_ready), .chop_polarity(chop_polarity), .mod_bit(mod_bit),
        .mod_strobe(mod_strobe), .at_stop(at_stop));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(a, 1'b0, 32'h0, r);
        check("hrdata", 64'(r), 64'(e));
    endtask : rd
    task automatic pop;
        res_ready <= 1'b1;
        @(posedge hclk);
        res_ready <= 1'b0;
        @(posedge hclk);
    endtask : pop
    task automatic wait_valid;
        while (res_valid !== 1'b1)
            @(posedge hclk);
    endtask : wait_valid
    // Configure, optionally switch channel mid-way, then time one result
    task automatic conv(input logic [31:0] ctrl, input logic lvl, input logic [31:0] n,
        input logic [63:0] v, input int pre);
        run <= 1'b0;
        level <= lvl;
        ahb(fsp_pkg::ADDR_CTRL, 1'b1, ctrl, q);
        if (pre > 0) begin
            run <= 1'b1;
            repeat (pre) @(posedge hclk);
            run <= 1'b0;
            @(posedge hclk);
            channel_change <= 1'b1;
            @(posedge hclk);
            channel_change <= 1'b0;
        end
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        run <= 1'b1;
        wait_valid();
        check("samples", 64'(at_stop), 64'(n));
        check("result", res_data, v);
        pop();
    endtask : conv
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("mod_ready", 64'(mod_ready), 64'h0);
        check("polarity", 64'(chop_polarity), 64'h0);
        rd(fsp_pkg::ADDR_CTRL, 32'h0000_6000);
        rd(32'h0000_000c, 32'h0);
        rd(fsp_pkg::ADDR_COUNT, 32'h0);
        for (int s = 1; s < 4; s++)
            conv(32'h101 | 32'(s << 1), s[0], 32'((2 + avg[s]) * 1024), s[0] ? FS : NEG, 0);
        // Sinc3 only here; SINC_ORDER fixes the filter order at 3 for every setting
        conv(32'h0000_0101, 1'b1, 32'd3072, FS, 0);
        conv(32'h0000_010b, 1'b1, 32'd8192, FS, 0);
        conv(32'h0000_0203, 1'b0, 32'd8192, 64'hffff_fffe_0000_0000, 0);
        rd(fsp_pkg::ADDR_CTRL, 32'h0000_0203);
        conv(32'h0000_0213, 1'b0, 32'd8192, 64'hffff_ffff_0000_0000, 0);
        conv(32'h0000_0103, 1'b1, 32'd4096, FS, 1500);
        repeat (100) @(posedge hclk);
        level <= 1'b0;
        wait_valid();
        check("step", 64'(res_data === FS || res_data === NEG), 64'h0);
        pop();
        wait_valid();
        check("settled", res_data, NEG);
        pop();
        run <= 1'b0;
        ahb(fsp_pkg::ADDR_CTRL, 1'b1, 32'h0000_0101, q);
        run <= 1'b1;
        repeat (12000) @(posedge hclk);
        run <= 1'b0;
        check("stall", 64'(mod_ready), 64'h0);
        ahb(fsp_pkg::ADDR_STATUS, 1'b0, 32'h0, q);
        check("level", 64'(q[19:16]), 64'h8);
        k = 0;
        while (res_valid === 1'b1 && k < 20) begin
            pop();
            k++;
        end
        check("drained", 64'(k), 64'h9);
        conclude();
    end
    initial begin
        repeat (95000) @(posedge hclk);
        n_fail++;
        conclude();
    end
endmodule : fsp_filter_tb
bind fsp_filter fsp_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mod_ready(mod_ready), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
